//--- hw/psia_pkg.sv
/*
 * Package for the PHY status, identifier and advertisement register bank:
 * register indices, field positions, reset values and carrier structs.
 * Assumes a 16-bit management register space reached by register index.
 */
package psia_pkg;

	// register indices on the management port
	localparam logic [4:0]  REG_PHY_STATUS      = 5'h01;
	localparam logic [4:0]  REG_PHY_IDENT_UPPER = 5'h02;
	localparam logic [4:0]  REG_PHY_IDENT_LOWER = 5'h03;
	localparam logic [4:0]  REG_NEG_ADVERTISE   = 5'h04;
	localparam logic [4:0]  REG_EVENT_STATUS    = 5'h18;
	localparam logic [4:0]  REG_EVENT_MASK      = 5'h19;

	// status bit positions
	localparam int STS_TX100_FULL  = 14;
	localparam int STS_TX100_HALF  = 13;
	localparam int STS_T10_FULL    = 12;
	localparam int STS_T10_HALF    = 11;
	localparam int STS_PREAMBLE_SUP = 6;
	localparam int STS_NEG_DONE    = 5;
	localparam int STS_REMOTE_FLT  = 4;
	localparam int STS_NEG_ABLE    = 3;
	localparam int STS_LINK        = 2;
	localparam int STS_JABBER      = 1;
	localparam int STS_EXT_CAP     = 0;

	// advertisement fields
	localparam int ADV_REMOTE_FLT = 13;
	localparam int ADV_TECH_LSB   = 5;
	localparam logic [7:0]  ADV_TECH_RESET  = 8'h2f;
	localparam logic [4:0]  ADV_SELECTOR    = 5'h01;

	// event bits: 0 link lost, 1 jabber, 2 negotiation done, 3 remote fault
	localparam int EVT_WIDTH = 4;
	localparam logic [3:0]  EVT_RESET = 4'h0;

	// management request bundle
	typedef struct packed {
		logic [4:0]  addr;
		logic [15:0] wrData;
		logic        wrStb;
		logic        rdStb;
	} psia_req_type;

	// live conditions from the negotiation, link and jabber logic
	typedef struct packed {
		logic negDone;
		logic remoteFault;
		logic linkUp;
		logic jabber;
		logic tenMbpsMode;
	} psia_cond_type;

	// whole register state of the bank
	typedef struct packed {
		logic                 linkLatch;
		logic                 jabberLatch;
		logic                 advRemoteFault;
		logic [7:0]           advTech;
		logic [EVT_WIDTH-1:0] evtStatus;
		logic [EVT_WIDTH-1:0] evtMask;
		logic [15:0]          rdData;
		logic                 irq;
	} psia_state_type;

endpackage : psia_pkg

//--- hw/psia_regs.sv
/*
 * Status, identifier and advertisement registers of a 10/100 PHY,
 * with latched link and jabber status and a small event interrupt.
 * Assumes a synchronous master with one-cycle strobes and read data
 * expected in the cycle after the read strobe.
 */
// How it works
// - 100BASE-TX abilities read one, zero while the ten-megabit strap holds.
// - 10BASE-T full and half duplex abilities always read one.
// - reserved status bits read zero; status register ignores writes.
// - preamble suppression ability reads zero; suppressed frames not accepted.
// - negotiation complete reads zero until negotiation finishes; resets zero.
// - remote fault status follows detected remote fault; resets zero.
// - negotiation ability bit reads one.
// - link status bit latches low, resets zero.
// - jabber bit latches high, only in 10BASE-T mode; resets zero.
// - extended capability bit reads one.
// - identifier registers two and three return fixed constants.
// - next page and reserved advertisement bit 14 read zero.
// - writable advertised remote fault, resets zero, sent to partner.
// - writable technology field, resets 00101111, advertised to partner.
// - selector field reads constant 00001.
// - latch-low captures a low event, latch-high a high event.
module psia_regs
	import psia_pkg::*;
#(
	parameter logic [15:0] IDENT_UPPER = 16'h1234, // arbitrary value
	parameter logic [15:0] IDENT_LOWER = 16'h5670  // arbitrary value
) (
	// clock and reset
	input  wire logic          core_clk,
	input  wire logic          rst_b,
	// management register port
	input  wire logic [4:0]    regAddr,
	input  wire logic [15:0]   regWrData,
	input  wire logic          regWrStb,
	input  wire logic          regRdStb,
	output logic      [15:0]   regRdData,
	// live conditions and strap
	input  wire logic          negDone,
	input  wire logic          remoteFault,
	input  wire logic          linkUp,
	input  wire logic          jabber,
	input  wire logic          tenMbpsMode,
	input  wire logic          tenMbpsAdvertiseLimitStrap,
	// advertisement to the negotiation logic
	output logic               advRemoteFault,
	output logic      [7:0]    advTech,
	// interrupt
	output logic               irq
);

	psia_req_type   req;
	psia_cond_type  cond;
	psia_state_type state_reg;
	psia_state_type state_next;
	logic           strap_reg;
	logic [15:0]    statusWord;
	logic [15:0]    advWord;
	logic [EVT_WIDTH-1:0] evtSet;
	logic           statusRead;

	// bundle inputs for the carrier structs
	assign req  = '{addr: regAddr, wrData: regWrData, wrStb: regWrStb, rdStb: regRdStb};
	assign cond = '{negDone: negDone, remoteFault: remoteFault, linkUp: linkUp,
		jabber: jabber, tenMbpsMode: tenMbpsMode};

	// strap caught by a clock edge, never by the async reset
	always_ff @(posedge core_clk) begin
		strap_reg <= tenMbpsAdvertiseLimitStrap;
	end

	assign statusRead = req.rdStb && (req.addr == REG_PHY_STATUS);

	// status word assembly; fixed bits are wires, not state
	always_comb begin
		statusWord                   = 16'h0000;
		statusWord[STS_TX100_FULL]   = ~strap_reg;
		statusWord[STS_TX100_HALF]   = ~strap_reg;
		statusWord[STS_T10_FULL]     = 1'b1;
		statusWord[STS_T10_HALF]     = 1'b1;
		statusWord[STS_PREAMBLE_SUP] = 1'b0;
		statusWord[STS_NEG_DONE]     = cond.negDone;
		statusWord[STS_REMOTE_FLT]   = cond.remoteFault;
		statusWord[STS_NEG_ABLE]     = 1'b1;
		statusWord[STS_LINK]         = state_reg.linkLatch;
		statusWord[STS_JABBER]       = state_reg.jabberLatch;
		statusWord[STS_EXT_CAP]      = 1'b1;
	end

	// advertisement word: next page and bit 14 stay zero
	always_comb begin
		advWord                              = 16'h0000;
		advWord[ADV_REMOTE_FLT]              = state_reg.advRemoteFault;
		advWord[ADV_TECH_LSB +: 8]           = state_reg.advTech;
		advWord[4:0]                         = ADV_SELECTOR;
	end

	// events: link loss, jabber, negotiation done, remote fault
	assign evtSet = {cond.remoteFault, cond.negDone,
		cond.jabber && cond.tenMbpsMode, ~cond.linkUp};

	// next state of the whole bank
	always_comb begin
		state_next = state_reg;
		// latches: a link drop holds zero and a 10M jabber holds one until a status read re-arms them
		if (statusRead) begin
			state_next.linkLatch   = cond.linkUp;
			state_next.jabberLatch = cond.jabber && cond.tenMbpsMode;
		end else begin
			state_next.linkLatch   = state_reg.linkLatch && cond.linkUp;
			state_next.jabberLatch = state_reg.jabberLatch ||
				(cond.jabber && cond.tenMbpsMode);
		end
		// writes; status and identifier registers ignore them
		if (req.wrStb) begin
			unique case (req.addr)
				REG_NEG_ADVERTISE: begin
					state_next.advRemoteFault = req.wrData[ADV_REMOTE_FLT];
					state_next.advTech        = req.wrData[ADV_TECH_LSB +: 8];
				end
				REG_EVENT_MASK: begin
					state_next.evtMask = req.wrData[EVT_WIDTH-1:0];
				end
				REG_EVENT_STATUS: begin
					state_next.evtStatus = state_reg.evtStatus & ~req.wrData[EVT_WIDTH-1:0];
				end
				default: begin
				end
			endcase
		end
		// set wins over a same-cycle clear
		state_next.evtStatus = state_next.evtStatus | evtSet;
		state_next.irq = |(state_next.evtStatus & state_next.evtMask);
		// read data stand only in the cycle after the strobe
		state_next.rdData = 16'h0000;
		if (req.rdStb) begin
			unique case (req.addr)
				REG_PHY_STATUS:      state_next.rdData = statusWord;
				REG_PHY_IDENT_UPPER: state_next.rdData = IDENT_UPPER;
				REG_PHY_IDENT_LOWER: state_next.rdData = IDENT_LOWER;
				REG_NEG_ADVERTISE:   state_next.rdData = advWord;
				REG_EVENT_STATUS:    state_next.rdData = {12'h000, state_reg.evtStatus};
				REG_EVENT_MASK:      state_next.rdData = {12'h000, state_reg.evtMask};
				default:             state_next.rdData = 16'h0000;
			endcase
		end
	end

	// one register stage for all state
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= '{linkLatch: 1'b0, jabberLatch: 1'b0, advRemoteFault: 1'b0,
				advTech: ADV_TECH_RESET, evtStatus: EVT_RESET, evtMask: EVT_RESET,
				rdData: 16'h0000, irq: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from flip-flops
	assign regRdData      = state_reg.rdData;
	assign advRemoteFault = state_reg.advRemoteFault;
	assign advTech        = state_reg.advTech;
	assign irq            = state_reg.irq;

	// checks
	// read data come from a register, so each read check looks one
	// cycle after the strobe and compares against $past of what the
	// bank saw at the strobe; the strap is compared through its own
	// register because the bank reacts to it one clock late
	// latch checks watch the internal latch bits directly: a status
	// read re-arms them at the same edge that captures the read word,
	// so only cycles without a read prove that a latch holds
	// event checks rely on set winning over a same-cycle clear; a
	// write-one-to-clear while the condition still holds leaves the
	// bit set, which software must allow for
	// none of these checks look at unknown values; the port inputs
	// are taken as synchronous to core_clk and settled at each edge
	AST_ABIL100: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(statusRead) |-> regRdData[14:13] == {2{~$past(strap_reg)}})
		else $error("100 Mbps ability bits wrong");
	AST_FIXED: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(statusRead) |-> regRdData[12:11] == 2'b11 && regRdData[3] && regRdData[0])
		else $error("fixed ability bits wrong");
	AST_RSVD: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(statusRead) |-> regRdData[15] == 1'b0 && regRdData[10:6] == 5'h00)
		else $error("reserved status bits not zero");
	AST_LINKLL: assert property (@(posedge core_clk) disable iff (!rst_b)
		(!linkUp && !statusRead) ##1 (!statusRead)[*2] |-> !state_reg.linkLatch)
		else $error("link drop not latched");
	AST_JABLH: assert property (@(posedge core_clk) disable iff (!rst_b)
		(jabber && tenMbpsMode && !statusRead) |=> state_reg.jabberLatch)
		else $error("jabber not latched");
	AST_REARM: assert property (@(posedge core_clk) disable iff (!rst_b)
		statusRead |=> state_reg.linkLatch == $past(linkUp))
		else $error("latch not re-armed after read");
	AST_IDENT: assert property (@(posedge core_clk) disable iff (!rst_b)
		(regRdStb && regAddr == REG_PHY_IDENT_UPPER) |=> regRdData == IDENT_UPPER)
		else $error("identifier upper wrong");
	AST_ADVWR: assert property (@(posedge core_clk) disable iff (!rst_b)
		(regWrStb && regAddr == REG_NEG_ADVERTISE) ##1 (regRdStb && regAddr == REG_NEG_ADVERTISE)
		|=> regRdData[12:5] == $past(regWrData[12:5], 2) && regRdData[15:14] == 2'b00
		&& regRdData[4:0] == ADV_SELECTOR)
		else $error("advertisement readback wrong");
	AST_NEGDONE: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(statusRead) |-> regRdData[5] == $past(negDone) && regRdData[4] == $past(remoteFault))
		else $error("negotiation or fault status wrong");

	// read port: data stand one cycle after the strobe, zero otherwise
	AST_RDZERO: assert property (@(posedge core_clk) disable iff (!rst_b)
		!$past(regRdStb) |-> regRdData == 16'h0000)
		else $error("read data not zero outside a read");

	AST_IDLOW: assert property (@(posedge core_clk) disable iff (!rst_b)
		(regRdStb && regAddr == REG_PHY_IDENT_LOWER) |=> regRdData == IDENT_LOWER)
		else $error("identifier lower wrong");

	AST_UNMAP: assert property (@(posedge core_clk) disable iff (!rst_b)
		(regRdStb && regAddr > REG_EVENT_MASK) |=> regRdData == 16'h0000)
		else $error("unmapped read not zero");

	AST_EVTSTSRD: assert property (@(posedge core_clk) disable iff (!rst_b)
		(regRdStb && regAddr == REG_EVENT_STATUS) |=> regRdData[15:4] == 12'h000)
		else $error("event status upper bits not zero");

	AST_EVTMSKRD: assert property (@(posedge core_clk) disable iff (!rst_b)
		(regRdStb && regAddr == REG_EVENT_MASK) |=> regRdData[15:4] == 12'h000)
		else $error("event mask upper bits not zero");

	// fixed status bits, seen in the cycle after a status read
	AST_RSV15: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(statusRead) |-> !regRdData[15])
		else $error("status bit 15 not zero");

	AST_RSV10: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(statusRead) |-> regRdData[10:7] == 4'h0)
		else $error("status bits 10 to 7 not zero");

	AST_T10: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(statusRead) |-> regRdData[12:11] == 2'b11)
		else $error("10BASE-T abilities not one");

	AST_NEGABLE: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(statusRead) |-> regRdData[3])
		else $error("negotiation ability not one");

	AST_EXTCAP: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(statusRead) |-> regRdData[0])
		else $error("extended capability not one");

	AST_NOPRE: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(statusRead) |-> !regRdData[6])
		else $error("preamble suppression ability not zero");

	AST_STRAPOFF: assert property (@(posedge core_clk) disable iff (!rst_b)
		($past(statusRead) && !$past(strap_reg)) |-> regRdData[14:13] == 2'b11)
		else $error("100 Mbps abilities missing without strap");

	AST_STRAPON: assert property (@(posedge core_clk) disable iff (!rst_b)
		($past(statusRead) && $past(strap_reg)) |-> regRdData[14:13] == 2'b00)
		else $error("100 Mbps abilities shown under strap");

	// live and latched status bits as read
	AST_RFSTS: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(statusRead) |-> regRdData[4] == $past(remoteFault))
		else $error("remote fault status wrong");

	AST_DONESTS: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(statusRead) |-> regRdData[5] == $past(negDone))
		else $error("negotiation complete status wrong");

	AST_LINKRD: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(statusRead) |-> regRdData[2] == $past(state_reg.linkLatch))
		else $error("link status read wrong");

	AST_JABRD: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(statusRead) |-> regRdData[1] == $past(state_reg.jabberLatch))
		else $error("jabber status read wrong");

	// latch behaviour between reads
	AST_LINKHOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
		(!state_reg.linkLatch && !statusRead) |=> !state_reg.linkLatch)
		else $error("link latch released without a read");

	AST_LINKKEEP: assert property (@(posedge core_clk) disable iff (!rst_b)
		(state_reg.linkLatch && linkUp) |=> state_reg.linkLatch)
		else $error("link latch dropped with link up");

	AST_LINKDROP: assert property (@(posedge core_clk) disable iff (!rst_b)
		!linkUp |=> !state_reg.linkLatch)
		else $error("link latch high after link loss");

	AST_JABHOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
		(state_reg.jabberLatch && !statusRead) |=> state_reg.jabberLatch)
		else $error("jabber latch released without a read");

	AST_JABSET: assert property (@(posedge core_clk) disable iff (!rst_b)
		(jabber && tenMbpsMode) |=> state_reg.jabberLatch)
		else $error("jabber latch not set");

	AST_JAB10: assert property (@(posedge core_clk) disable iff (!rst_b)
		(!tenMbpsMode && !state_reg.jabberLatch) |=> !state_reg.jabberLatch)
		else $error("jabber latched outside 10BASE-T");

	AST_JABREARM: assert property (@(posedge core_clk) disable iff (!rst_b)
		statusRead |=> state_reg.jabberLatch == ($past(jabber) && $past(tenMbpsMode)))
		else $error("jabber latch not re-armed after read");

	// advertisement register
	AST_NEXTPG: assert property (@(posedge core_clk) disable iff (!rst_b)
		(regRdStb && regAddr == REG_NEG_ADVERTISE) |=> regRdData[15:14] == 2'b00)
		else $error("next page or bit 14 not zero");

	AST_SELECT: assert property (@(posedge core_clk) disable iff (!rst_b)
		(regRdStb && regAddr == REG_NEG_ADVERTISE) |=> regRdData[4:0] == ADV_SELECTOR)
		else $error("selector field wrong");

	AST_ADVRF: assert property (@(posedge core_clk) disable iff (!rst_b)
		(regRdStb && regAddr == REG_NEG_ADVERTISE) |=> regRdData[13] == $past(advRemoteFault))
		else $error("advertised remote fault read wrong");

	AST_ADVTECH: assert property (@(posedge core_clk) disable iff (!rst_b)
		(regRdStb && regAddr == REG_NEG_ADVERTISE) |=> regRdData[12:5] == $past(advTech))
		else $error("technology field read wrong");

	AST_WRRF: assert property (@(posedge core_clk) disable iff (!rst_b)
		(regWrStb && regAddr == REG_NEG_ADVERTISE) |=> advRemoteFault == $past(regWrData[13]))
		else $error("advertised remote fault not written");

	AST_WRTECH: assert property (@(posedge core_clk) disable iff (!rst_b)
		(regWrStb && regAddr == REG_NEG_ADVERTISE) |=> advTech == $past(regWrData[12:5]))
		else $error("technology field not written");

	AST_RFHOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
		!(regWrStb && regAddr == REG_NEG_ADVERTISE) |=> $stable(advRemoteFault))
		else $error("advertised remote fault changed without write");

	AST_TECHHOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
		!(regWrStb && regAddr == REG_NEG_ADVERTISE) |=> $stable(advTech))
		else $error("technology field changed without write");

	// events and interrupt
	AST_EVTNEG: assert property (@(posedge core_clk) disable iff (!rst_b)
		negDone |=> state_reg.evtStatus[2])
		else $error("negotiation event not set");

	AST_EVTLINK: assert property (@(posedge core_clk) disable iff (!rst_b)
		!linkUp |=> state_reg.evtStatus[0])
		else $error("link loss event not set");

	AST_EVTJAB: assert property (@(posedge core_clk) disable iff (!rst_b)
		(jabber && tenMbpsMode) |=> state_reg.evtStatus[1])
		else $error("jabber event not set");

	AST_EVTRF: assert property (@(posedge core_clk) disable iff (!rst_b)
		remoteFault |=> state_reg.evtStatus[3])
		else $error("remote fault event not set");

	AST_W1C: assert property (@(posedge core_clk) disable iff (!rst_b)
		(regWrStb && regAddr == REG_EVENT_STATUS && regWrData[2] && !negDone) |=> !state_reg.evtStatus[2])
		else $error("event not cleared by write of one");

	AST_IRQMSK: assert property (@(posedge core_clk) disable iff (!rst_b)
		(regWrStb && regAddr == REG_EVENT_MASK && regWrData[3:0] == 4'h0) |=> !irq)
		else $error("interrupt high with all events masked");

	COV_LINKDROP: cover property (@(posedge core_clk) disable iff (!rst_b)
		linkUp ##1 !linkUp ##1 linkUp ##1 statusRead);
	COV_IRQ: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(irq));
	COV_ADV: cover property (@(posedge core_clk) disable iff (!rst_b)
		regWrStb && regAddr == REG_NEG_ADVERTISE);
	COV_JAB: cover property (@(posedge core_clk) disable iff (!rst_b)
		(jabber && tenMbpsMode && !state_reg.jabberLatch) ##1 state_reg.jabberLatch);
	COV_STRAP: cover property (@(posedge core_clk) disable iff (!rst_b)
		statusRead && strap_reg);

endmodule : psia_regs

//--- tb/psia_mgmt_master.sv
/*
 * Management master model: drives one-cycle write and read strobes
 * on the register port and picks up read data in the following cycle.
 * Assumes the register bank never makes the master wait.
 */
module psia_mgmt_master
	import psia_pkg::*;
(
	// clock
	input  wire logic        core_clk,
	// register port
	output logic      [4:0]  regAddr,
	output logic      [15:0] regWrData,
	output logic             regWrStb,
	output logic             regRdStb,
	input  wire logic [15:0] regRdData
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle port from time zero
	initial begin
		regAddr = 5'h00;
		regWrData = 16'h0000;
		regWrStb = 1'b0;
		regRdStb = 1'b0;
	end

	// one write cycle; the strobe stands for one clock edge only
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge core_clk);
		regWrStb <= 1'b0;
		#1;
	endtask : wr

	// one read cycle; data only stands in the cycle after the strobe
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge core_clk);
		regRdStb <= 1'b0;
		#1;
		d = regRdData;
	endtask : rd
endmodule : psia_mgmt_master

//--- tb/tb_psia_regs.sv
/*
 * Testbench of the status, identifier and advertisement register bank.
 * Assumes a 100 MHz clock and the management master model beside it.
 */
module tb_psia_regs
	import psia_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] ID_HI = 16'h0abc; // arbitrary value
	localparam logic [15:0] ID_LO = 16'h0def; // arbitrary value
	logic        core_clk = 1'b0, rst_b = 1'b0, regWrStb, regRdStb;
	logic [4:0]  regAddr;
	logic [15:0] regWrData, regRdData, rdv;
	logic        negDone = 1'b0, remoteFault = 1'b0, linkUp = 1'b0, jabber = 1'b0;
	logic        tenMbpsMode = 1'b0, tenMbpsAdvertiseLimitStrap = 1'b0, advRemoteFault, irq;
	logic [7:0]  advTech;
	int          miscompares = 0, numChecks = 0;

	// free-running clock
	always #5 core_clk = ~core_clk;

	psia_regs #(.IDENT_UPPER(ID_HI), .IDENT_LOWER(ID_LO)) psia_regs_inst (.core_clk(core_clk), .rst_b(rst_b),
		.regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
		.regRdData(regRdData), .negDone(negDone), .remoteFault(remoteFault), .linkUp(linkUp),
		.jabber(jabber), .tenMbpsMode(tenMbpsMode), .tenMbpsAdvertiseLimitStrap(tenMbpsAdvertiseLimitStrap),
		.advRemoteFault(advRemoteFault), .advTech(advTech), .irq(irq));
	psia_mgmt_master psia_mgmt_master_inst (.core_clk(core_clk), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		numChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// read a register and compare the whole word
	task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
		psia_mgmt_master_inst.rd(a, rdv);
		chk(rdv, exp);
	endtask : rdchk

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict

	// reset values; link down, strap idle
	task automatic t_reset();
		chk({7'h00, advRemoteFault, advTech}, {8'h00, ADV_TECH_RESET});
		chk({15'h0000, irq}, 16'h0000);
		rdchk(REG_PHY_STATUS, 16'h7809);
		rdchk(REG_PHY_IDENT_UPPER, ID_HI);
		rdchk(REG_PHY_IDENT_LOWER, ID_LO);
		rdchk(REG_NEG_ADVERTISE, 16'h05e1);
		rdchk(5'h1f, 16'h0000);
	endtask : t_reset

	// ten-megabit strap removes both 100BASE-TX abilities
	task automatic t_strap();
		@(posedge core_clk) tenMbpsAdvertiseLimitStrap <= 1'b1;
		@(posedge core_clk);
		rdchk(REG_PHY_STATUS, 16'h1809);
		@(posedge core_clk) tenMbpsAdvertiseLimitStrap <= 1'b0;
		@(posedge core_clk);
	endtask : t_strap

	// writes to read-only places, all-ones then zero to advertisement
	task automatic t_writes();
		psia_mgmt_master_inst.wr(REG_PHY_STATUS, 16'hffff);
		psia_mgmt_master_inst.wr(REG_PHY_IDENT_UPPER, 16'hffff);
		rdchk(REG_PHY_STATUS, 16'h7809);
		rdchk(REG_PHY_IDENT_UPPER, ID_HI);
		psia_mgmt_master_inst.wr(REG_NEG_ADVERTISE, 16'hffff);
		rdchk(REG_NEG_ADVERTISE, 16'h3fe1);
		chk({7'h00, advRemoteFault, advTech}, 16'h01ff);
		psia_mgmt_master_inst.wr(REG_NEG_ADVERTISE, 16'h0000);
		rdchk(REG_NEG_ADVERTISE, 16'h0001);
		chk({7'h00, advRemoteFault, advTech}, 16'h0000);
	endtask : t_writes

	// link latches low until read, jabber latches high only at 10M
	task automatic t_latch();
		@(posedge core_clk) linkUp <= 1'b1;
		rdchk(REG_PHY_STATUS, 16'h7809);
		rdchk(REG_PHY_STATUS, 16'h780d);
		@(posedge core_clk) linkUp <= 1'b0;
		@(posedge core_clk) linkUp <= 1'b1;
		rdchk(REG_PHY_STATUS, 16'h7809);
		rdchk(REG_PHY_STATUS, 16'h780d);
		@(posedge core_clk) jabber <= 1'b1;
		@(posedge core_clk) jabber <= 1'b0;
		rdchk(REG_PHY_STATUS, 16'h780d);
		@(posedge core_clk) {tenMbpsMode, jabber} <= 2'b11;
		@(posedge core_clk) jabber <= 1'b0;
		rdchk(REG_PHY_STATUS, 16'h780f);
		rdchk(REG_PHY_STATUS, 16'h780d);
		@(posedge core_clk) {negDone, remoteFault} <= 2'b11;
		rdchk(REG_PHY_STATUS, 16'h783d);
		@(posedge core_clk) {negDone, remoteFault} <= 2'b00;
		rdchk(REG_PHY_STATUS, 16'h780d);
	endtask : t_latch

	// event status clear, mask, interrupt level
	task automatic t_irq();
		psia_mgmt_master_inst.wr(REG_EVENT_STATUS, 16'h000f);
		rdchk(REG_EVENT_STATUS, 16'h0000);
		psia_mgmt_master_inst.wr(REG_EVENT_MASK, 16'h0004);
		rdchk(REG_EVENT_MASK, 16'h0004);
		chk({15'h0000, irq}, 16'h0000);
		@(posedge core_clk) negDone <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1 chk({15'h0000, irq}, 16'h0001);
		psia_mgmt_master_inst.wr(REG_EVENT_MASK, 16'h0000);
		@(posedge core_clk) negDone <= 1'b0;
		#1 chk({15'h0000, irq}, 16'h0000);
		psia_mgmt_master_inst.wr(REG_EVENT_STATUS, 16'h000f);
		rdchk(REG_EVENT_STATUS, 16'h0000);
	endtask : t_irq

	// main sequence
	initial begin
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		#1;
		t_reset();
		t_strap();
		t_writes();
		t_latch();
		t_irq();
		print_verdict();
	end

	// watchdog; the whole run needs well under a thousand cycles
	initial begin
		#20000;
		miscompares++;
		print_verdict();
	end
endmodule : tb_psia_regs
